// [src/dsc_pkg.sv]
/*
 * Shared constants for the DMA service chain and auto-reload block:
 * register offsets, field positions, reset values and port numbering.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package dsc_pkg;

  localparam int NUM_CH = 6;
  localparam int NUM_PORTS = 4;
  localparam int NUM_REQ = 7;
  localparam int ID_W = 3;
  localparam int ADDR_W = 8;

  // Requester numbering along the chain; host sits after channel 5
  localparam logic [2:0] HOST_ID = 3'h6;

  // Port numbering
  localparam int PORT_DUAL_RAM = 0;
  localparam int PORT_SINGLE_RAM = 1;
  localparam int PORT_EXTERNAL = 2;
  localparam int PORT_PERIPH = 3;

  // Register byte offsets
  localparam logic [7:0] CH_CTRL_BASE = 8'h00;
  localparam logic [7:0] GLOBAL_CTRL_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;

  // channel_control fields
  localparam int CC_SYNC_EN_BIT = 5;
  localparam int CC_CHANNEL_PRIORITY_BIT = 6;
  localparam int CC_ENABLE_BIT = 7;
  localparam int CC_AUTO_BIT = 8;
  localparam int CC_REPEAT_BIT = 9;
  localparam int CC_END_OF_PROGRAMMING_FLAG_BIT = 11;
  localparam logic [15:0] CC_RESET = 16'h0000;
  localparam logic [15:0] CC_WMASK = 16'h0be0;

  // global_control fields
  localparam int GC_HOST_CHANNEL_PRIORITY_BIT = 0;
  localparam int GC_HOST_EXCL_BIT = 1;
  localparam logic [15:0] GC_RESET = 16'h0000;
  localparam logic [15:0] GC_WMASK = 16'h0003;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Gray coded along stopped -> running -> waiting for programming
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_RUN = 2'b01,
    CH_WAIT_PROG = 2'b11
  } dsc_ch_state_t;

endpackage

// [src/dsc_top.sv]
/*
 * DMA service chain arbiter for four ports plus per-channel
 * auto-reload control, with an AXI4-Lite register slave.
 * Assumes channel request, port usage, block-done and element-done
 * inputs come from logic on the same clock.
 */
// Operation
// - Control bit 8 enables automatic channel reload between blocks.
// - Auto-reload off: channel stops after the current block ends.
// - Auto-reload on: reload context and start a new block.
// - Clearing enable halts the channel immediately.
// - Clearing auto-reload mid-block finishes the block, then stops.
// - Repeat bit set: reload after each block, ignoring end flag.
// - Repeat bit clear: wait for end-of-programming flag before reload.
// - After copying context, hardware clears the end-of-programming flag.
// - Host-exclusive clear: host shares both RAM ports and the external port with channels.
// - Host-exclusive set: no host external access, RAM ports host only.
// - Each port arbitrates six channels and host independently.
// - All four port chains use one shared configuration.
// - Low priority served only when no high priority request waits.
// - Reset puts all channels and host at low priority.
// - Chain order is channel 0 to 5, then host, repeating.
// - Serve current position if ready and no higher priority waits.
// - After reset each chain restarts at channel 0.
// - Enabled channel connected only while running, disabled skipped; reset disconnects all.
// - Peripheral port never grants the host.
// - Channel waiting on sync event raises no request.
// - Port considers channel only if channel uses that port.
// - Granted port stays with requester until element completes.
`timescale 1ns/1ps

module dsc_top
  import dsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel side
  input wire logic [NUM_CH-1:0] ch_req,
  input wire logic [NUM_CH*NUM_PORTS-1:0] ch_port_use,
  input wire logic [NUM_CH-1:0] ch_sync_event,
  input wire logic [NUM_CH-1:0] ch_block_done,
  output logic [NUM_CH-1:0] ch_running,
  output logic [NUM_CH-1:0] ch_reload,
  // Host side
  input wire logic [NUM_PORTS-1:0] host_req,
  // Port side
  input wire logic [NUM_PORTS-1:0] port_elem_done,
  output logic [NUM_PORTS-1:0] port_grant_valid,
  output logic [NUM_PORTS*ID_W-1:0] port_grant_id
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [15:0] ch_ctrl_r [NUM_CH];
  logic [15:0] glb_ctrl_r;
  dsc_ch_state_t ch_state_r [NUM_CH];
  logic [NUM_CH-1:0] sync_seen_r;
  logic [NUM_CH-1:0] reload_r;
  logic [NUM_CH-1:0] running_r;

  logic [2:0] ptr_r [NUM_PORTS];
  logic [NUM_PORTS-1:0] busy_r;
  logic [ID_W-1:0] owner_r [NUM_PORTS];

  logic [ADDR_W-1:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  logic wr_fire;
  logic [NUM_CH-1:0] cc_wr_sel;
  logic gc_wr_sel;
  logic wr_mapped;
  logic [15:0] wr_val16;
  logic [15:0] wr_mask16;

  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    return word_ofs(a) <= STATUS_OFS;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
  assign wr_mapped = reg_mapped(aw_addr_r);
  assign wr_val16 = w_data_r[15:0];
  assign wr_mask16 = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign gc_wr_sel = wr_fire && word_ofs(aw_addr_r) == GLOBAL_CTRL_OFS;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      cc_wr_sel[i] = wr_fire &&
        word_ofs(aw_addr_r) == CH_CTRL_BASE + 8'(4 * i);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      awready_r <= 1'b0;
    end else if (s_axi_awvalid && awready_r) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      awready_r <= 1'b0;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end else begin
      awready_r <= !aw_have_r && !bvalid_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      wready_r <= 1'b0;
    end else if (s_axi_wvalid && wready_r) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      wready_r <= 1'b0;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end else begin
      wready_r <= !w_have_r && !bvalid_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= '0;
      if (word_ofs(s_axi_araddr) == GLOBAL_CTRL_OFS) begin
        rdata_r[15:0] <= glb_ctrl_r;
      end else if (word_ofs(s_axi_araddr) == STATUS_OFS) begin
        // Active (not idle) flags low, waiting-for-programming flags above
        for (int i = 0; i < NUM_CH; i++) begin
          rdata_r[i] <= ch_state_r[i] != CH_IDLE;
          rdata_r[8 + i] <= ch_state_r[i] == CH_WAIT_PROG;
        end
        rdata_r[19:16] <= busy_r;
      end else begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (word_ofs(s_axi_araddr) == CH_CTRL_BASE + 8'(4 * i)) begin
            rdata_r[15:0] <= ch_ctrl_r[i];
          end
        end
      end
    end else if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end else begin
      arready_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      glb_ctrl_r <= GC_RESET;
    end else if (gc_wr_sel) begin
      glb_ctrl_r <= (glb_ctrl_r & ~(wr_mask16 & GC_WMASK)) |
        (wr_val16 & wr_mask16 & GC_WMASK);
    end
  end

  // End flag: a software write of 1 wins over the hardware clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_ctrl_r[i] <= CC_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (cc_wr_sel[i]) begin
          ch_ctrl_r[i] <= (ch_ctrl_r[i] & ~(wr_mask16 & CC_WMASK)) |
            (wr_val16 & wr_mask16 & CC_WMASK);
          if (reload_r[i] && !(wr_mask16[CC_END_OF_PROGRAMMING_FLAG_BIT] &&
              wr_val16[CC_END_OF_PROGRAMMING_FLAG_BIT])) begin
            ch_ctrl_r[i][CC_END_OF_PROGRAMMING_FLAG_BIT] <= 1'b0;
          end
        end else if (reload_r[i]) begin
          ch_ctrl_r[i][CC_END_OF_PROGRAMMING_FLAG_BIT] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel block sequencing

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_state_r[i] <= CH_IDLE;
      end
      reload_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        reload_r[i] <= 1'b0;
        if (!ch_ctrl_r[i][CC_ENABLE_BIT]) begin
          ch_state_r[i] <= CH_IDLE;
        end else begin
          unique case (ch_state_r[i])
            CH_IDLE: begin
              // Left only by a write of enable = 1, below
            end
            CH_RUN: begin
              if (ch_block_done[i]) begin
                if (!ch_ctrl_r[i][CC_AUTO_BIT]) begin
                  ch_state_r[i] <= CH_IDLE;
                end else if (ch_ctrl_r[i][CC_REPEAT_BIT]) begin
                  reload_r[i] <= 1'b1;
                end else if (ch_ctrl_r[i][CC_END_OF_PROGRAMMING_FLAG_BIT]) begin
                  reload_r[i] <= 1'b1;
                end else begin
                  ch_state_r[i] <= CH_WAIT_PROG;
                end
              end
            end
            CH_WAIT_PROG: begin
              if (!ch_ctrl_r[i][CC_AUTO_BIT]) begin
                ch_state_r[i] <= CH_IDLE;
              end else if (ch_ctrl_r[i][CC_REPEAT_BIT] ||
                  ch_ctrl_r[i][CC_END_OF_PROGRAMMING_FLAG_BIT]) begin
                reload_r[i] <= 1'b1;
                ch_state_r[i] <= CH_RUN;
              end
            end
            default: begin
              ch_state_r[i] <= CH_IDLE;
            end
          endcase
        end
        // Outside the enable test: the old enable is still 0 on a start
        if (cc_wr_sel[i] && wr_mask16[CC_ENABLE_BIT] &&
            wr_val16[CC_ENABLE_BIT] && (ch_state_r[i] == CH_IDLE ||
            !ch_ctrl_r[i][CC_ENABLE_BIT])) begin
          ch_state_r[i] <= CH_RUN;
          reload_r[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        running_r[i] <= ch_state_r[i] == CH_RUN &&
          ch_ctrl_r[i][CC_ENABLE_BIT];
      end
    end
  end

  // Sync event is held until the next context reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_seen_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_sync_event[i]) begin
          sync_seen_r[i] <= 1'b1;
        end else if (reload_r[i]) begin
          sync_seen_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Service chains, one per port, sharing one configuration

  function automatic logic [NUM_REQ-1:0] ready_set(input int p);
    logic [NUM_REQ-1:0] r;
    logic excl;
    r = '0;
    excl = glb_ctrl_r[GC_HOST_EXCL_BIT];
    for (int i = 0; i < NUM_CH; i++) begin
      r[i] = ch_req[i] && running_r[i] &&
        (!ch_ctrl_r[i][CC_SYNC_EN_BIT] || sync_seen_r[i]) &&
        ch_port_use[i * NUM_PORTS + p];
      if (excl && (p == PORT_DUAL_RAM || p == PORT_SINGLE_RAM)) begin
        r[i] = 1'b0;
      end
    end
    r[NUM_REQ-1] = host_req[p] && p != PORT_PERIPH &&
      !(excl && p == PORT_EXTERNAL);
    return r;
  endfunction

  function automatic logic [NUM_REQ-1:0] channel_priority_set();
    logic [NUM_REQ-1:0] h;
    for (int i = 0; i < NUM_CH; i++) begin
      h[i] = ch_ctrl_r[i][CC_CHANNEL_PRIORITY_BIT];
    end
    h[NUM_REQ-1] = glb_ctrl_r[GC_HOST_CHANNEL_PRIORITY_BIT];
    return h;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        ptr_r[p] <= 3'h0;
        owner_r[p] <= '0;
      end
      busy_r <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        logic [NUM_REQ-1:0] rdy;
        logic [NUM_REQ-1:0] hi;
        logic hi_pend;
        rdy = ready_set(p);
        hi = channel_priority_set();
        hi_pend = |(rdy & hi);
        if (busy_r[p]) begin
          if (port_elem_done[p]) begin
            busy_r[p] <= 1'b0;
          end
        end else begin
          if (rdy[ptr_r[p]] && (hi[ptr_r[p]] || !hi_pend)) begin
            busy_r[p] <= 1'b1;
            owner_r[p] <= ptr_r[p];
          end
          ptr_r[p] <= ptr_r[p] == HOST_ID ? 3'h0 : ptr_r[p] + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_grant_id[p*ID_W +: ID_W] = owner_r[p];
    end
  end

  assign port_grant_valid = busy_r;
  assign ch_running = running_r;
  assign ch_reload = reload_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// [sim/dsc_chk_sva.sv]
/* Checker for the service chain arbiter and auto-reload ports.
   Assumes one clock, aresetn synchronous active low, bound to dsc_top. */
`timescale 1ns/1ps
module dsc_chk
  import dsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_CH*NUM_PORTS-1:0] ch_port_use,
  input wire logic [NUM_CH-1:0] ch_running,
  input wire logic [NUM_CH-1:0] ch_reload,
  input wire logic [NUM_PORTS-1:0] port_elem_done,
  input wire logic [NUM_PORTS-1:0] port_grant_valid,
  input wire logic [NUM_PORTS*ID_W-1:0] port_grant_id
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] id2;
  assign id2 = port_grant_id[8:6];
  ////////////////////////////////////////////////////////////////////
  sequence elem_end;
    port_elem_done[2] ##1 !port_grant_valid[2];
  endsequence
  sequence new_ch_grant;
    $rose(port_grant_valid[2]) && id2 < 3'h6;
  endsequence
  ////////////////////////////////////////////////////////////////////
  chk_host_periph: assert property (
    port_grant_valid[3] |-> port_grant_id[11:9] != HOST_ID)
    else $error("host granted on peripheral port");
  chk_grant_hold: assert property (
    port_grant_valid[2] && !port_elem_done[2] |=>
      port_grant_valid[2] && $stable(id2))
    else $error("grant moved before element end");
  chk_grant_drop: assert property (
    port_grant_valid[2] && port_elem_done[2] |-> elem_end)
    else $error("grant kept after element end");
  chk_grant_used: assert property (
    new_ch_grant |-> ch_port_use[{id2, 2'b10}])
    else $error("grant to channel not using port");
  chk_grant_running: assert property (
    new_ch_grant |-> ch_running[id2])
    else $error("grant to stopped channel");
  chk_reset_clear: assert property (
    $rose(aresetn) |-> port_grant_valid == 4'h0 && ch_running == 6'h00)
    else $error("state not cleared by reset");
  chk_reload_run: assert property (
    ch_reload[0] |=> ch_running[0] && !ch_reload[0])
    else $error("reload not followed by run");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
endmodule

bind dsc_top dsc_chk dsc_chk_i (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .ch_port_use, .ch_running,
  .ch_reload, .port_elem_done, .port_grant_valid, .port_grant_id);

// [sim/dsc_partner.sv]
/* Element engines behind the four ports: end each granted element.
   Assumes grants on the same clock; slow stretches each element. */
`timescale 1ns/1ps
module dsc_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic [3:0] port_grant_valid,
  output logic [3:0] port_elem_done
);
  logic [1:0] cnt_r [4];
  // Count restarts after each end, so one grant is never ended twice
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 4; p++) begin
      if (!aresetn || !port_grant_valid[p] || port_elem_done[p]) begin
        cnt_r[p] <= 2'h0;
        port_elem_done[p] <= 1'b0;
      end else begin
        cnt_r[p] <= cnt_r[p] + 2'h1;
        port_elem_done[p] <= cnt_r[p] == (slow ? 2'h3 : 2'h0);
      end
    end
  end
endmodule

// [sim/dsc_top_bench.sv]
/* Self-checking bench for dsc_top: registers over AXI4-Lite,
   arbitration and auto-reload. Assumes dsc_partner ends elements. */
`timescale 1ns/1ps
module dsc_top_bench;
  import dsc_pkg::*;
  typedef struct packed {
    logic [2:0] id;
    logic [1:0] port;
    logic [15:0] ctrl;
  } dsc_row_t;
  logic aclk, aresetn, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, host_req, port_elem_done, port_grant_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [23:0] ch_port_use;
  logic [5:0] ch_req, ch_sync_event, ch_block_done, ch_running, ch_reload;
  logic [11:0] port_grant_id;
  logic [2:0] g, p;
  dsc_row_t r;
  dsc_row_t rows [4] = '{'{3'h0, 2'h2, 16'h0080}, '{3'h3, 2'h3, 16'h00c0},
    '{3'h5, 2'h0, 16'h0380}, '{3'h6, 2'h1, 16'h0000}};
  int err_count = 0, checks_done = 0, cyc = 0, rl_cnt = 0, n0;

  dsc_top dsc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch_req, .ch_port_use,
    .ch_sync_event, .ch_block_done, .ch_running, .ch_reload, .host_req,
    .port_elem_done, .port_grant_valid, .port_grant_id);
  dsc_partner dsc_partner_i (.aclk, .aresetn, .slow, .port_grant_valid,
    .port_elem_done);

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (ch_reload[0] === 1'b1) rl_cnt <= rl_cnt + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ad, wd;
    {ad, wd} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task automatic gnt(input int pt);
    g = 3'h7;
    while (port_grant_valid[pt]) @(posedge aclk);
    for (int n = 0; n < 40 && g === 3'h7; n++) begin
      @(posedge aclk);
      if (port_grant_valid[pt]) g = port_grant_id[pt*3+:3];
    end
  endtask
  task automatic idle();
    ch_req <= 0;
    host_req <= 0;
    do @(posedge aclk); while (port_grant_valid !== 4'h0);
  endtask
  task automatic blk();
    ch_block_done <= 6'h01;
    @(posedge aclk);
    ch_block_done <= 6'h00;
    repeat (4) @(posedge aclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, ch_req, ch_port_use, ch_sync_event} = '0;
    {ch_block_done, host_req} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int a = 0; a <= 28; a += 4) begin
      rd(8'(a));
      chk("reset value", d, 0);
    end
    rd(8'h20);
    chk("unmapped", {rs, d[29:0]}, 32'h80000000);
    wr(8'h20, 32'h00000001);
    chk("unmapped write", rs, 2'h2);
    chk("grants", {ch_running, port_grant_valid}, 0);
    foreach (rows[k]) begin
      r = rows[k];
      if (r.id == HOST_ID) host_req[r.port] <= 1'b1;
      else begin
        ch_port_use <= 24'h1 << (int'(r.id) * 4 + int'(r.port));
        ch_req <= 6'h1 << r.id;
        wr({3'h0, r.id, 2'h0}, r.ctrl);
        rd({3'h0, r.id, 2'h0});
        chk("control", d, r.ctrl);
      end
      gnt(r.port);
      chk("grant id", g, r.id);
      idle();
      wr({3'h0, r.id, 2'h0}, 0);
    end
    // Low channel 1 against high channel 4 on the external port
    slow <= 1;
    ch_port_use <= 24'h040040;
    wr(8'h04, 16'h0080);
    wr(8'h10, 16'h00c0);
    ch_req <= 6'h12;
    gnt(2);
    chk("high first", g, 4);
    gnt(2);
    chk("high again", g, 4);
    ch_req <= 6'h02;
    gnt(2);
    chk("low served", g, 1);
    idle();
    slow <= 0;
    wr(8'h10, 0);
    ch_port_use <= 24'h004404;
    wr(8'h00, 16'h0080);
    wr(8'h08, 16'h0080);
    wr(8'h0c, 16'h0080);
    ch_req <= 6'h0d;
    gnt(2);
    repeat (3) begin
      p = g;
      gnt(2);
      chk("order", g, p == 0 ? 3'h2 : p == 2 ? 3'h3 : 3'h0);
    end
    idle();
    wr(8'h04, 0);
    wr(8'h08, 0);
    wr(8'h0c, 0);
    // Host exclusive: channel 0 on the dual RAM port is ignored
    wr(GLOBAL_CTRL_OFS, 2);
    chk("write okay", rs, 2'h0);
    ch_port_use <= 24'h000001;
    ch_req <= 6'h01;
    host_req <= 4'hd;
    gnt(0);
    chk("host only", g, HOST_ID);
    gnt(2);
    chk("no external", g, 3'h7);
    gnt(3);
    chk("no periph", g, 3'h7);
    host_req <= 0;
    repeat (4) @(posedge aclk);
    gnt(0);
    chk("channel cut", g, 3'h7);
    idle();
    wr(GLOBAL_CTRL_OFS, 0);
    ch_port_use <= 24'h000400;
    ch_req <= 6'h04;
    wr(8'h08, 16'h00a0);
    gnt(2);
    chk("no event", g, 3'h7);
    ch_sync_event <= 6'h04;
    @(posedge aclk);
    ch_sync_event <= 6'h00;
    gnt(2);
    chk("after event", g, 2);
    idle();
    wr(8'h08, 0);
    // Auto-reload on channel 0 through each repeat setting
    wr(8'h00, 16'h0180);
    n0 = rl_cnt;
    blk();
    chk("held reload", rl_cnt - n0, 0);
    rd(STATUS_OFS);
    chk("waiting", d, 32'h00000101);
    wr(8'h00, 16'h0980);
    repeat (3) @(posedge aclk);
    chk("reload", rl_cnt - n0, 1);
    rd(8'h00);
    chk("end flag", d[11], 0);
    wr(8'h00, 16'h0380);
    blk();
    chk("repeat reload", rl_cnt - n0, 2);
    wr(8'h00, 16'h0080);
    blk();
    chk("stopped", {rl_cnt - n0, ch_running[0]}, 4);
    wr(8'h00, 16'h0180);
    repeat (3) @(posedge aclk);
    chk("restart", ch_running[0], 1);
    wr(8'h00, 0);
    repeat (2) @(posedge aclk);
    chk("halted", ch_running[0], 0);
    // Reset in mid-grant clears grants and disconnects channels
    slow <= 1;
    ch_port_use <= 24'h000004;
    ch_req <= 6'h01;
    wr(8'h00, 16'h0080);
    gnt(2);
    chk("grant before reset", g, 0);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("reset grants", {ch_running, port_grant_valid}, 0);
    rd(8'h00);
    chk("reset control", d, 0);
    gnt(2);
    chk("no grant after reset", g, 3'h7);
    report_and_stop();
  end
endmodule
